/* File: logic/cco_regs.vh */
// Purpose: constants for the complement, compare and decimal-adjust execution block
// Assumes: 16-bit program words, 8-bit data, 4-bit bank select, 12-bit data address
// Notes: definitions only
`ifndef CCO_REGS_VH
`define CCO_REGS_VH

// opcode fields
`define CCO_OP6_COMPLEMENT_FILE_OP      6'h07
`define CCO_OP7_CMP_LT    7'h30
`define CCO_OP7_CMP_EQ    7'h31
`define CCO_OP7_CMP_GT    7'h32
`define CCO_OP_DAW        16'h0007
`define CCO_DEST_BIT      9
`define CCO_ACC_BIT       8

// access bank mapping
`define CCO_ACC_SPLIT     8'h80
`define CCO_ACC_BANK_LO   4'h0
`define CCO_ACC_BANK_HI   4'hF

// decimal adjust
`define CCO_BCD_MAX       4'h9
`define CCO_BCD_LO_ADJ    9'h006
`define CCO_BCD_HI_ADJ    9'h060

// phases of one instruction cycle
`define CCO_Q1            2'h0
`define CCO_Q2            2'h1
`define CCO_Q3            2'h2
`define CCO_Q4            2'h3

// reset values
`define CCO_W_RST         8'h00
`define CCO_FLAG_RST      1'b0
`define CCO_INSTR_RST     16'h0000

`endif

/* File: logic/cco_phase.v */
// Purpose: four-phase sequencer of the instruction cycle
// Assumes: one clock; PHASE_DIV clocks per phase
// Notes: tick is a one-cycle enable at the last clock of each phase
`timescale 1ns/1ps
module cco_phase #(
   parameter PHASE_DIV = 1
) (
   input  wire       clk,
   input  wire       rst_n,
   output reg  [1:0] phase_r,
   output wire       tick
);
   `include "cco_regs.vh"

   reg [7:0] div_r;

   assign tick = (div_r == PHASE_DIV[7:0] - 8'h01);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r   <= 8'h00;
         phase_r <= `CCO_Q1;
      end else if (tick) begin
         div_r   <= 8'h00;
         phase_r <= phase_r + 2'h1;
      end else begin
         div_r   <= div_r + 8'h01;
      end
   end
endmodule // cco_phase

/* File: logic/cco_ram.v */
// Purpose: byte-wide data memory with registered read
// Assumes: one write and one read port on the same clock
// Notes: read data appear the clock after rd_en
`timescale 1ns/1ps
module cco_ram #(
   parameter AW = 12,
   parameter DW = 8
) (
   input  wire          clk,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   input  wire          rd_en,
   input  wire [AW-1:0] rd_addr,
   output reg  [DW-1:0] rd_data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // cco_ram

/* File: logic/cco_core.v */
// Purpose: executes complement-file, three compare-and-skip ops and decimal adjust
// Assumes: fetch logic presents instr_word through Q1 and next_two_word by Q3
// Notes: other opcodes run as no_operation here; flags and working register live here
//
// What this block does
// - complement-file writes inverted byte to destination, updates only negative and zero
// - destination bit clear: to working register; set: back to file register
// - access bit clear forces access bank; set uses bank select register
// - compare-equal subtracts working register from byte, skips when equal
// - compare-greater skips only when byte exceeds working register, unsigned
// - compare-less skips only when byte is below working register, unsigned
// - compares change no flag and not the working register
// - on skip the fetched next instruction becomes one no_operation cycle
// - skipping a two-word instruction costs two no_operation cycles, three total
// - decimal adjust adds six to low nibble if above nine or digit carry
// - adds six to high nibble if above nine or carry; only carry flags change
// - decimal adjust is one word, one cycle, may set carry regardless
`timescale 1ns/1ps
module cco_core #(
   parameter PHASE_DIV = 1,
   parameter AW        = 12
) (
   input  wire          clk,
   input  wire          arst_n,
   input  wire [15:0]   instr_word,
   input  wire          next_two_word,
   input  wire [3:0]    bank_select_register,
   input  wire          ext_w_wr,
   input  wire [7:0]    ext_w_data,
   input  wire          ext_flag_wr,
   input  wire          ext_carry,
   input  wire          ext_digit_carry,
   input  wire          ext_zero,
   input  wire          ext_negative,
   input  wire          ext_mem_wr,
   input  wire [AW-1:0] ext_mem_addr,
   input  wire [7:0]    ext_mem_data,
   output reg  [7:0]    working_register,
   output reg           carry,
   output reg           digit_carry_flag,
   output reg           zero,
   output reg           negative,
   output reg           instr_done,
   output reg           skip_active,
   output reg           no_operation,
   output reg  [1:0]    cycle_phase
);
   `include "cco_regs.vh"

   localparam ST_RUN   = 2'h0;
   localparam ST_SKIP1 = 2'h1;
   localparam ST_SKIP2 = 2'h2;

   reg          rst_s1_r;
   reg          rst_n_r;
   wire [1:0]   phase;
   wire         tick;
   reg  [1:0]   st_r;
   reg  [1:0]   st_nxt;
   reg  [15:0]  ir_r;
   reg  [7:0]   res_r;
   reg          res_to_w_r;
   reg          res_to_f_r;
   reg          cmp_hit_r;
   wire [7:0]   rd_byte;
   wire         q1_end;
   wire         q2_end;
   wire         q3_end;
   wire         q4_end;
   wire         running;
   wire         op_complement_file_op;
   wire         op_lt;
   wire         op_eq;
   wire         op_gt;
   wire         op_daw;
   wire         uses_file;
   wire [7:0]   f_addr;
   wire [AW-1:0] mem_addr;
   wire [8:0]   diff;
   wire         cmp_equal;
   wire         cmp_less;
   wire         cmp_greater;
   wire         lo_adj;
   wire         hi_adj;
   wire [8:0]   daw_lo;
   wire [8:0]   daw_sum;
   wire         core_wr;
   wire         mem_wr;
   wire [AW-1:0] mem_wr_addr;
   wire [7:0]   mem_wr_data;

   // reset release through two flops
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   cco_phase #(
      .PHASE_DIV (PHASE_DIV)
   ) u_phase (
      .clk     (clk),
      .rst_n   (rst_n_r),
      .phase_r (phase),
      .tick    (tick)
   );

   assign q1_end  = tick && (phase == `CCO_Q1);
   assign q2_end  = tick && (phase == `CCO_Q2);
   assign q3_end  = tick && (phase == `CCO_Q3);
   assign q4_end  = tick && (phase == `CCO_Q4);
   assign running = (st_r == ST_RUN);

   // decode of the latched word
   assign op_complement_file_op = (ir_r[15:10] == `CCO_OP6_COMPLEMENT_FILE_OP);
   assign op_lt   = (ir_r[15:9] == `CCO_OP7_CMP_LT);
   assign op_eq   = (ir_r[15:9] == `CCO_OP7_CMP_EQ);
   assign op_gt   = (ir_r[15:9] == `CCO_OP7_CMP_GT);
   assign op_daw  = (ir_r == `CCO_OP_DAW);
   assign uses_file = op_complement_file_op || op_lt || op_eq || op_gt;

   // bank choice for the file operand
   assign f_addr   = ir_r[7:0];
   assign mem_addr = ir_r[`CCO_ACC_BIT] ? {bank_select_register, f_addr} :
                     (f_addr >= `CCO_ACC_SPLIT) ? {`CCO_ACC_BANK_HI, f_addr} :
                                                  {`CCO_ACC_BANK_LO, f_addr};

   // unsigned subtraction only decides the skip
   assign diff        = {1'b0, rd_byte} - {1'b0, working_register};
   assign cmp_equal   = (diff == 9'h000);
   assign cmp_less    = diff[8];
   assign cmp_greater = !diff[8] && !cmp_equal;

   // decimal adjust: both tests use the nibbles as they were
   assign lo_adj  = (working_register[3:0] > `CCO_BCD_MAX) || digit_carry_flag;
   assign hi_adj  = (working_register[7:4] > `CCO_BCD_MAX) || carry;
   assign daw_lo  = {1'b0, working_register} + (lo_adj ? `CCO_BCD_LO_ADJ : 9'h000);
   assign daw_sum = daw_lo + (hi_adj ? `CCO_BCD_HI_ADJ : 9'h000);

   // core write beats a pending external write in the same clock
   assign core_wr     = q4_end && running && res_to_f_r;
   assign mem_wr      = core_wr || ext_mem_wr;
   assign mem_wr_addr = core_wr ? mem_addr : ext_mem_addr;
   assign mem_wr_data = core_wr ? res_r : ext_mem_data;

   cco_ram #(
      .AW (AW),
      .DW (8)
   ) u_ram (
      .clk     (clk),
      .wr_en   (mem_wr),
      .wr_addr (mem_wr_addr),
      .wr_data (mem_wr_data),
      .rd_en   (q2_end && running && uses_file),
      .rd_addr (mem_addr),
      .rd_data (rd_byte)
   );

   // skip sequencing
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_RUN: begin
            if (cmp_hit_r) begin
               st_nxt = next_two_word ? ST_SKIP2 : ST_SKIP1;
            end
         end
         ST_SKIP2: begin
            st_nxt = ST_SKIP1;
         end
         ST_SKIP1: begin
            st_nxt = ST_RUN;
         end
         default: begin
            st_nxt = ST_RUN;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r <= ST_RUN;
      end else if (q4_end) begin
         st_r <= st_nxt;
      end
   end

   // Q1 decode: latch the word; discarded words are never latched
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ir_r <= `CCO_INSTR_RST;
      end else if (q1_end) begin
         ir_r <= running ? instr_word : `CCO_INSTR_RST;
      end
   end

   // Q3 process
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         res_r      <= `CCO_W_RST;
         res_to_w_r <= 1'b0;
         res_to_f_r <= 1'b0;
         cmp_hit_r  <= 1'b0;
      end else if (q3_end) begin
         res_r      <= op_daw ? daw_sum[7:0] : ~rd_byte;
         res_to_w_r <= running && ((op_complement_file_op && !ir_r[`CCO_DEST_BIT]) || op_daw);
         res_to_f_r <= running && op_complement_file_op && ir_r[`CCO_DEST_BIT];
         cmp_hit_r  <= running && ((op_eq && cmp_equal) || (op_gt && cmp_greater) ||
                                   (op_lt && cmp_less));
      end else if (q4_end) begin
         cmp_hit_r  <= 1'b0;
      end
   end

   // Q4 write: working register and flags
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         working_register <= `CCO_W_RST;
         carry            <= `CCO_FLAG_RST;
         digit_carry_flag <= `CCO_FLAG_RST;
         zero             <= `CCO_FLAG_RST;
         negative         <= `CCO_FLAG_RST;
      end else if (q4_end && running) begin
         if (res_to_w_r) begin
            working_register <= res_r;
         end
         if (op_complement_file_op) begin
            negative <= res_r[7];
            zero     <= (res_r == 8'h00);
         end
         if (op_daw) begin
            carry            <= carry | daw_sum[8];
            digit_carry_flag <= 1'b0;
         end
      end else begin
         // except at the Q4 write edge of a running cycle the rest of the core may load them; compares never do
         if (ext_w_wr) begin
            working_register <= ext_w_data;
         end
         if (ext_flag_wr) begin
            carry            <= ext_carry;
            digit_carry_flag <= ext_digit_carry;
            zero             <= ext_zero;
            negative         <= ext_negative;
         end
      end
   end

   // status outputs
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         instr_done   <= 1'b0;
         skip_active  <= 1'b0;
         no_operation <= 1'b0;
         cycle_phase  <= `CCO_Q1;
      end else begin
         instr_done   <= q4_end;
         skip_active  <= !running;
         no_operation <= !running || !(uses_file || op_daw);
         cycle_phase  <= phase;
      end
   end
endmodule // cco_core

/* File: sim/cco_core_chk.sv */
// Purpose: concurrent checks on the ports of cco_core
// Assumes: PHASE_DIV of 1, so one phase per clock
// Notes: bound to every cco_core instance
`timescale 1ns/1ps
`include "cco_regs.vh"
module cco_core_chk #(
   parameter PHASE_DIV = 1
) (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic [15:0] instr_word,
   input wire logic        next_two_word,
   input wire logic        ext_w_wr,
   input wire logic [7:0]  working_register,
   input wire logic        carry,
   input wire logic        digit_carry_flag,
   input wire logic        zero,
   input wire logic        negative,
   input wire logic        instr_done,
   input wire logic        skip_active,
   input wire logic        no_operation,
   input wire logic [1:0]  cycle_phase
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // done rises at the write edge, three clocks after the latch edge, so $past(instr_word) is the word held at the write edge
   a_done_period: assert property (instr_done |=> !instr_done [*3] ##1 instr_done)
      else $error("instr_done not every four clocks");
   a_done_phase: assert property (instr_done |-> cycle_phase == `CCO_Q4)
      else $error("instr_done outside last phase");
   a_w_at_q4: assert property (!$stable(working_register) && !$past(ext_w_wr) |-> instr_done)
      else $error("working register changed off the write phase");
   // the write edge is the only edge the done sample sees; ext loads are shut out there
   a_cmp_keep: assert property (instr_done && !skip_active &&
      $past(instr_word[15:9]) inside {`CCO_OP7_CMP_LT, `CCO_OP7_CMP_EQ, `CCO_OP7_CMP_GT}
      |-> $stable({working_register, carry, digit_carry_flag, zero, negative}))
      else $error("compare changed state");
   a_complement_file_op_flags: assert property (instr_done && !skip_active &&
      $past(instr_word[15:10]) == `CCO_OP6_COMPLEMENT_FILE_OP |-> $stable({carry, digit_carry_flag}))
      else $error("complement touched carry flags");
   a_adj_flags: assert property (instr_done && !skip_active &&
      $past(instr_word) == `CCO_OP_DAW |-> $stable({zero, negative}))
      else $error("decimal adjust touched zero or negative");
   a_skip_cause: assert property ($rose(skip_active) |->
      $past(instr_word[15:9], 5) inside {`CCO_OP7_CMP_LT, `CCO_OP7_CMP_EQ, `CCO_OP7_CMP_GT})
      else $error("skip without a compare");
   a_skip_noop: assert property (skip_active |-> no_operation && !$rose(working_register))
      else $error("skip cycle not idle");
   a_skip_one: assert property ($rose(skip_active) && !$past(next_two_word, 2)
      |-> skip_active [*4] ##1 !skip_active)
      else $error("single skip not one cycle");
   a_skip_two: assert property ($rose(skip_active) && $past(next_two_word, 2)
      |-> skip_active [*8] ##1 !skip_active)
      else $error("two-word skip not two cycles");
endmodule // cco_core_chk

bind cco_core cco_core_chk #(.PHASE_DIV(PHASE_DIV)) cco_core_chk_inst (.clk, .arst_n, .instr_word,
   .next_two_word, .ext_w_wr, .working_register, .carry, .digit_carry_flag, .zero, .negative,
   .instr_done, .skip_active, .no_operation, .cycle_phase);

/* File: sim/cpu_complement_compare_bcd_ops_test.sv */
// Purpose: directed bench for cco_core
// Assumes: PHASE_DIV of 1; flags packed as {carry, digit carry, zero, negative}
// Notes: ext loads land in filler cycles, never on a write phase
`timescale 1ns/1ps
`include "cco_regs.vh"
module cpu_complement_compare_bcd_ops_test;
   logic        clk = 1'b0, arst_n = 1'b0, next_two_word = 1'b0;
   logic        ext_w_wr = 1'b0, ext_flag_wr = 1'b0, ext_mem_wr = 1'b0;
   logic        ext_carry = 1'b0, ext_digit_carry = 1'b0, ext_zero = 1'b0, ext_negative = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [3:0]  bank_select_register = 4'h0;
   logic [7:0]  ext_w_data = 8'h00, ext_mem_data = 8'h00, working_register;
   logic [11:0] ext_mem_addr = 12'h000, snap;
   logic        carry, digit_carry_flag, zero, negative, instr_done, skip_active, no_operation;
   logic [1:0]  cycle_phase;
   int          errors = 0, n_compared = 0, ticks = 0;

   cco_core #(.PHASE_DIV(1)) cco_core_inst (.clk, .arst_n, .instr_word, .next_two_word,
      .bank_select_register, .ext_w_wr, .ext_w_data, .ext_flag_wr, .ext_carry, .ext_digit_carry,
      .ext_zero, .ext_negative, .ext_mem_wr, .ext_mem_addr, .ext_mem_data, .working_register,
      .carry, .digit_carry_flag, .zero, .negative, .instr_done, .skip_active, .no_operation,
      .cycle_phase);

   always #4 clk = ~clk;
   // hang guard: the whole run needs well under a thousand clocks
   always @(posedge clk) begin
      ticks++;
      if (ticks == 3000) begin
         errors++;
         give_verdict;
      end
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic sync;
      @(posedge clk);
      #1;
      while (instr_done !== 1'b1) begin
         @(posedge clk);
         #1;
      end
   endtask

   // one clock of working register, flags and one memory byte, inside a filler cycle
   task automatic load(input logic [7:0] w, input logic [3:0] f, input logic [11:0] a,
                       input logic [7:0] d);
      sync;
      {ext_w_data, ext_mem_addr, ext_mem_data} = {w, a, d};
      {ext_carry, ext_digit_carry, ext_zero, ext_negative} = f;
      {ext_w_wr, ext_flag_wr, ext_mem_wr} = 3'h7;
      @(posedge clk);
      #1 {ext_w_wr, ext_flag_wr, ext_mem_wr} = 3'h0;
   endtask

   // w is latched at the first edge after sync, nxt is the word that may be skipped
   task automatic run(input logic [15:0] w, input logic [15:0] nxt, input logic s);
      sync;
      instr_word = w;
      repeat (4) @(posedge clk);
      #1 instr_word = nxt;
      repeat (3) @(posedge clk);
      #1 snap = {carry, digit_carry_flag, zero, negative, working_register};
      @(posedge clk);
      #1 check({11'h000, skip_active}, {11'h000, s});
      instr_word = 16'h0000;
   endtask

   task automatic t_complement;
      bank_select_register = 4'h5;
      load(8'h55, 4'hC, 12'h013, 8'h13);
      run(16'h1C13, 16'h0000, 1'b0);
      check(snap, {4'hD, 8'hEC});
      load(8'h55, 4'hC, 12'h520, 8'hFF);
      run(16'h1F20, 16'h0000, 1'b0);
      check(snap, {4'hE, 8'h55});
      run(16'h1D20, 16'h0000, 1'b0);
      check(snap, {4'hD, 8'hFF});
      load(8'h00, 4'h0, 12'hF90, 8'h3C);
      run(16'h1C90, 16'h0000, 1'b0);
      check(snap, {4'h1, 8'hC3});
   endtask

   // unsigned boundary around 0x80, where a signed compare would flip
   task automatic t_compare;
      logic [6:0] op;
      logic [7:0] fv;
      logic       hit;
      bank_select_register = 4'h3;
      load(8'h00, 4'h0, 12'h013, 8'h13);
      for (int k = 0; k < 9; k++) begin
         op = `CCO_OP7_CMP_LT + 7'(k / 3);
         fv = 8'h7F + 8'(k % 3);
         hit = op == `CCO_OP7_CMP_EQ ? fv == 8'h80 : op == `CCO_OP7_CMP_GT ? fv > 8'h80 : fv < 8'h80;
         load(8'h80, 4'hA, 12'h340, fv);
         run({op, 1'b1, 8'h40}, 16'h1C13, hit);
         check(snap, {4'hA, 8'h80});
         sync;
         check({11'h000, skip_active}, 12'h000);
         check({4'h0, working_register}, hit ? 12'h080 : 12'h0EC);
      end
   endtask

   task automatic t_two_word;
      load(8'h22, 4'h0, 12'h340, 8'h22);
      next_two_word = 1'b1;
      run(16'h6340, 16'h0000, 1'b1);
      repeat (4) @(posedge clk);
      #1 check({11'h000, skip_active}, 12'h001);
      repeat (4) @(posedge clk);
      #1 check({11'h000, skip_active}, 12'h000);
      next_two_word = 1'b0;
   endtask

   // entries: w in, flags in, w out, flags out
   task automatic t_adjust;
      logic [23:0] t [6] = '{24'hA5305B, 24'hCE334B, 24'h127183, 24'h99BF9B, 24'h003003, 24'h000000};
      for (int k = 0; k < 6; k++) begin
         load(t[k][23:16], t[k][15:12], 12'h000, 8'h00);
         run(`CCO_OP_DAW, 16'h0000, 1'b0);
         check(snap, {t[k][3:0], t[k][11:4]});
      end
   endtask

   task automatic give_verdict;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (2) @(posedge clk);
      #1 check({carry, digit_carry_flag, zero, negative, working_register}, 12'h000);
      t_complement;
      t_compare;
      t_two_word;
      t_adjust;
      give_verdict;
   end
endmodule // cpu_complement_compare_bcd_ops_test
